/* rtl/pspt_pkg.sv */
// Shared constants, types and states of the supply status and serial target block
package pspt_pkg;
  // Fixed upper address bits of the two serial targets
  localparam logic [3:0] MCU_ADDR_HI = 4'hb; // Monitoring controller
  localparam logic [3:0] EEP_ADDR_HI = 4'ha; // Identity memory
  // Command codes of the monitoring controller
  localparam logic [7:0] CMD_STATUS = 8'h80; // Vendor status byte
  localparam logic [7:0] CMD_NV = 8'hd0; // Storage access, then address byte
  localparam logic [7:0] CMD_FAN_CMD = 8'h21; // Unsupported fan command
  localparam logic [7:0] CMD_FAN_STAT = 8'h81; // Unsupported fan status
  localparam logic [7:0] CMD_RD_VIN = 8'h88; // Unsupported input voltage
  localparam logic [7:0] CMD_RD_IIN = 8'h89; // Unsupported input current
  localparam logic [7:0] CMD_RD_FAN1 = 8'h90; // Unsupported fan speed 1
  localparam logic [7:0] CMD_RD_FAN2 = 8'h91; // Unsupported fan speed 2
  localparam logic [7:0] CMD_RD_PIN = 8'ha3; // Unsupported input power
  localparam logic [7:0] CMD_LEG_FAN1 = 8'he0; // legacy_first_fan_query
  localparam logic [7:0] CMD_LEG_FAN2 = 8'he1; // legacy_second_fan_query
  localparam logic [7:0] CMD_LEG_VIN = 8'he2; // legacy_input_voltage_query
  localparam logic [7:0] CMD_LEG_IIN = 8'he3; // legacy_input_current_query
  localparam logic [7:0] CMD_LEG_PIN = 8'he4; // Legacy input power query
  // Storage sizes
  localparam logic [6:0] NV_SIZE = 7'h60; // 96 bytes in the controller
  localparam int EE_BYTES = 128; // Identity memory bytes
  localparam int NV_BYTES = 96; // Controller storage bytes
  localparam logic [7:0] ERASED_BYTE = 8'hff; // Reset and unmapped read value
  // Vendor status byte layout
  localparam int VS_NOIRQ_BIT = 5; // 1 while no interrupt pending
  // Synchroniser reset value: lines idle high, straps high, write protected
  localparam logic [13:0] SYNC_RST = 14'h3fff;
  // Over-temperature warning lead time
  localparam int WARN_S = 10; // Seconds of warning before shutdown
  localparam int CLK_HZ = 100_000_000; // System clock rate
  localparam int WARN_CYC = WARN_S * CLK_HZ; // Warning length in cycles
  // Status inputs from the power stage
  typedef struct packed {
    logic in_ok; // Input within limits
    logic out_on; // Main output present
    logic remote_on; // Remote on/off high
    logic ovp; // Over-voltage
    logic ocp; // Over-current
    logic ot_alarm; // Over-temperature alarm
    logic ot_fault; // Over-temperature fault
    logic irq; // Interrupt pending
  } pspt_stat_t;
  // Front indicators, 1 = lit
  typedef struct packed {
    logic input_green; // Input lamp
    logic output_green; // Output lamp
    logic fault_lamp; // Fault lamp, red
  } pspt_led_t;
  // Open-collector monitor outputs, enable high sinks the line low
  typedef struct packed {
    logic fault; // Fault line
    logic output_good_signal; // Output good line
    logic input_good_output; // Input good line
    logic temp_good; // Temperature good line
  } pspt_mon_t;
  // Serial target states, Gray along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_WR = 3'b010,
    ST_RD = 3'b110,
    ST_RACK = 3'b111
  } pspt_state_t;
endpackage

/* rtl/pspt_top.sv */
// Supply status, indicator mapping and serial bus targets of the rectifier
`timescale 1ns/100ps
module pspt_top import pspt_pkg::*; #(
  parameter int WARN_CYCLES = WARN_CYC // Warning length, shorten in simulation
) (
  input wire logic sys_clk_i, // System clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic scl_i, // Serial clock from host
  input wire logic sda_i, // Serial data line level
  output logic sda_o, // Serial data drive value
  output logic sda_oe_o, // Serial data drive enable
  input wire logic strap_select_high_i, // Address strap, upper
  input wire logic strap_select_mid_i, // Address strap, middle
  input wire logic strap_select_low_i, // Address strap, lower
  input wire logic write_protect_i, // High blocks identity writes
  input wire pspt_stat_t stat_i, // Power stage status
  output pspt_led_t led_o, // Front indicators
  output pspt_mon_t mon_o, // Monitor line values
  output pspt_mon_t mon_oe_o, // Monitor line sink enables
  output logic host_alert_line_o, // Alert line value
  output logic host_alert_line_oe_o, // Alert line sink enable
  output logic unit_presence_flag_o, // Presence line value
  output logic unit_presence_flag_oe_o, // Presence line sink enable
  output logic shutdown_o // Thermal shutdown request
);

  localparam logic [29:0] WARN_LAST = 30'(WARN_CYCLES - 1); // Last warning count

  // Command codes that the controller refuses
  function automatic logic unsup(input logic [7:0] c);
    unsup = (c == CMD_FAN_CMD) || (c == CMD_FAN_STAT) || (c == CMD_RD_VIN) ||
            (c == CMD_RD_IIN) || (c == CMD_RD_FAN1) || (c == CMD_RD_FAN2) ||
            (c == CMD_RD_PIN) || (c == CMD_LEG_FAN1) || (c == CMD_LEG_FAN2) ||
            (c == CMD_LEG_VIN) || (c == CMD_LEG_IIN) || (c == CMD_LEG_PIN);
  endfunction

  logic [13:0] sync1_r; // First synchroniser stage
  logic [13:0] sync2_r; // Second synchroniser stage
  logic scl_q_r; // Previous serial clock
  logic sda_q_r; // Previous serial data
  pspt_state_t st_r; // Target state
  logic [3:0] cnt_r; // Bit counter
  logic [7:0] sh_r; // Shift register
  logic eep_r; // 1 = identity memory addressed
  logic rw_r; // Read transfer
  logic [1:0] bcnt_r; // Written bytes, saturating
  logic [7:0] cmd_r; // Last controller command
  logic [6:0] ptr_r; // Byte pointer
  logic sda_oe_r; // Data line sink
  logic [7:0] nv_r [0:NV_BYTES-1]; // Controller storage
  logic [7:0] ee_r [0:EE_BYTES-1]; // Identity storage
  logic [29:0] warn_cnt_r; // Warning time counter
  logic shut_r; // Thermal shutdown active
  pspt_led_t led_r; // Registered indicators
  pspt_mon_t mon_oe_r; // Registered monitor sinks
  logic alert_r; // Registered alert sink

  // Synchronised inputs
  wire s_scl = sync2_r[13]; // Serial clock
  wire s_sda = sync2_r[12]; // Serial data
  wire [2:0] strap = sync2_r[11:9]; // Address straps
  wire wp = sync2_r[8]; // Write protect
  pspt_stat_t st_in; // Status inputs
  assign st_in = pspt_stat_t'(sync2_r[7:0]);

  // Bus events
  wire scl_rise = s_scl & ~scl_q_r; // Clock rising edge
  wire scl_fall = ~s_scl & scl_q_r; // Clock falling edge
  wire bus_start = s_scl & scl_q_r & sda_q_r & ~s_sda; // Start or repeated start
  wire bus_stop = s_scl & scl_q_r & ~sda_q_r & s_sda; // Stop
  wire byte_end = scl_fall & (cnt_r == 4'h8); // Eighth bit finished

  // Address match against fixed bits and straps
  wire mcu_hit = (sh_r[7:1] == {MCU_ADDR_HI, strap});
  wire eep_hit = (sh_r[7:1] == {EEP_ADDR_HI, strap});

  // Write-side decisions
  wire wr_done = (st_r == ST_WR) & byte_end & ~bus_start & ~bus_stop; // Byte received
  wire wr_ack = eep_r | (bcnt_r != 2'd0) | ~unsup(sh_r);
  wire nv_we = wr_done & ~eep_r & (bcnt_r == 2'd2) & (cmd_r == CMD_NV) & (ptr_r < NV_SIZE);
  wire ee_we = wr_done & eep_r & (bcnt_r != 2'd0) & ~wp;

  // Thermal and fault conditions
  wire ot_flt = st_in.ot_fault | shut_r; // Over-temperature fault
  wire fault_cond = ~st_in.in_ok | ~st_in.out_on | ~st_in.remote_on |
                    st_in.ovp | st_in.ocp | ot_flt;

  // Vendor status byte
  wire [7:0] vendor_status_byte = {2'b00, ~st_in.irq, ~st_in.in_ok, st_in.ot_alarm,
                                   ot_flt, st_in.ocp, st_in.ovp};

  // Read data selection
  wire [7:0] mcu_byte = (cmd_r == CMD_STATUS) ? vendor_status_byte :
                        ((cmd_r == CMD_NV) && (ptr_r < NV_SIZE)) ? nv_r[ptr_r] :
                        ERASED_BYTE;
  wire [7:0] rd_byte = eep_r ? ee_r[ptr_r] : mcu_byte;

  // Two-stage synchroniser for all pin inputs
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {scl_i, sda_i, strap_select_high_i, strap_select_mid_i,
                  strap_select_low_i, write_protect_i, stat_i};
      sync2_r <= sync1_r;
    end
  end

  // Previous line levels for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= s_scl;
      sda_q_r <= s_sda;
    end
  end

  // Serial target sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      eep_r <= 1'b0;
      rw_r <= 1'b0;
      bcnt_r <= 2'd0;
      cmd_r <= 8'h00;
      ptr_r <= 7'h00;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      // Stop ends any transfer
      st_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      // Start opens address phase; command and pointer survive repeats
      st_r <= ST_ADDR;
      cnt_r <= 4'h0;
      bcnt_r <= 2'd0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], s_sda};
            cnt_r <= 4'(cnt_r + 4'h1);
          end else if (byte_end) begin
            if (mcu_hit || eep_hit) begin
              // Matching address is acknowledged
              st_r <= ST_ACK;
              eep_r <= eep_hit;
              rw_r <= sh_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            // Release acknowledge, then receive or send
            cnt_r <= 4'h0;
            if (rw_r) begin
              st_r <= ST_RD;
              sh_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= ST_WR;
              sda_oe_r <= 1'b0;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], s_sda};
            cnt_r <= 4'(cnt_r + 4'h1);
          end else if (byte_end) begin
            if (bcnt_r != 2'd2) begin
              bcnt_r <= 2'(bcnt_r + 2'd1);
            end
            // Command, address and pointer handling
            if (eep_r) begin
              ptr_r <= (bcnt_r == 2'd0) ? sh_r[6:0] : 7'(ptr_r + 7'h1);
            end else if (bcnt_r == 2'd0) begin
              cmd_r <= sh_r;
            end else if (cmd_r == CMD_NV) begin
              ptr_r <= (bcnt_r == 2'd1) ? sh_r[6:0] : 7'(ptr_r + 7'h1);
            end
            if (wr_ack) begin
              st_r <= ST_ACK;
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_r <= 4'(cnt_r + 4'h1);
          end else if (byte_end) begin
            // Byte sent, release for host acknowledge
            st_r <= ST_RACK;
            sda_oe_r <= 1'b0;
            ptr_r <= 7'(ptr_r + 7'h1);
          end else if (scl_fall) begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe_r <= ~sh_r[6];
          end
        end
        ST_RACK: begin
          if (scl_rise && s_sda) begin
            st_r <= ST_IDLE; // Host ended the read
          end else if (scl_fall) begin
            st_r <= ST_RD;
            cnt_r <= 4'h0;
            sh_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
          end
        end
        default: begin
          st_r <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Controller storage
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NV_BYTES; i++) begin
        nv_r[i] <= ERASED_BYTE;
      end
    end else if (nv_we) begin
      nv_r[ptr_r] <= sh_r;
    end
  end

  // Identity storage
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_r[i] <= ERASED_BYTE;
      end
    end else if (ee_we) begin
      ee_r[ptr_r] <= sh_r;
    end
  end

  // Thermal warning timer and shutdown
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      warn_cnt_r <= 30'h0;
      shut_r <= 1'b0;
    end else if (!st_in.ot_alarm) begin
      warn_cnt_r <= 30'h0; // Recovered, restart allowed
      shut_r <= 1'b0;
    end else if (!shut_r) begin
      warn_cnt_r <= 30'(warn_cnt_r + 30'h1);
      shut_r <= (warn_cnt_r == WARN_LAST);
    end
  end

  // Indicator and monitor mapping
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      led_r <= '0;
      mon_oe_r <= '0;
      alert_r <= 1'b0;
    end else begin
      led_r.input_green <= st_in.in_ok;
      led_r.output_green <= ~fault_cond;
      led_r.fault_lamp <= fault_cond;
      mon_oe_r.fault <= fault_cond;
      mon_oe_r.output_good_signal <= fault_cond;
      mon_oe_r.input_good_output <= ~st_in.in_ok;
      mon_oe_r.temp_good <= st_in.ot_alarm | ot_flt;
      alert_r <= st_in.irq;
    end
  end

  // Output drive
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_r;
  assign led_o = led_r;
  assign mon_o = '0;
  assign mon_oe_o = mon_oe_r;
  assign host_alert_line_o = 1'b0;
  assign host_alert_line_oe_o = alert_r;
  assign unit_presence_flag_o = 1'b0;
  assign unit_presence_flag_oe_o = 1'b1;
  assign shutdown_o = shut_r;

endmodule

/* sim/pspt_sva.sv */
// Checker of status mapping, warning timer and data line turnaround
`timescale 1ns/100ps
module pspt_sva import pspt_pkg::*; #(
  parameter int WARN_CYCLES = 50 // Warning length in cycles
) (
  input wire logic sys_clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic scl_i, // Serial clock
  input wire pspt_stat_t stat_i, // Status inputs
  input wire logic sda_o, // Data value
  input wire logic sda_oe_o, // Data sink enable
  input wire pspt_led_t led_o, // Lamps
  input wire pspt_mon_t mon_o, // Monitor values
  input wire pspt_mon_t mon_oe_o, // Monitor sink enables
  input wire logic host_alert_line_o, // Alert value
  input wire logic host_alert_line_oe_o, // Alert sink enable
  input wire logic unit_presence_flag_o, // Presence value
  input wire logic unit_presence_flag_oe_o, // Presence sink enable
  input wire logic shutdown_o // Thermal shutdown
);
  logic [1:0] rcnt_r; // Edges since release, saturating
  logic sd_q1_r; // Shutdown one cycle ago
  logic sd_q2_r; // Shutdown two cycles ago
  int alarm_cnt_r; // Consecutive alarm cycles
  wire settled = rcnt_r == 2'd3; // Sync pipeline refilled
  wire sd_any = shutdown_o | sd_q1_r | sd_q2_r; // Shutdown lately
  // Fault condition from raw status, shutdown aside
  function automatic logic fc(pspt_stat_t s);
    return !s.in_ok | !s.out_on | !s.remote_on | s.ovp | s.ocp | s.ot_fault;
  endfunction
  // Helper counters
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rcnt_r <= 2'd0;
      alarm_cnt_r <= 0;
    end else begin
      rcnt_r <= settled ? rcnt_r : rcnt_r + 2'd1;
      alarm_cnt_r <= stat_i.ot_alarm ? alarm_cnt_r + 1 : 0;
    end
    sd_q1_r <= shutdown_o;
    sd_q2_r <= sd_q1_r;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Alarm quiet long enough for the sync and clear
  sequence s_alarm_quiet;
    !stat_i.ot_alarm [*4];
  endsequence
  a_presence_sink: assert property (unit_presence_flag_oe_o && !unit_presence_flag_o)
    else $error("presence line not sinking");
  a_open_drain: assert property (!sda_o && !host_alert_line_o && mon_o == 4'h0)
    else $error("open drain line driven high");
  a_alert_follow: assert property (settled |-> host_alert_line_oe_o == $past(stat_i.irq, 3))
    else $error("alert line does not follow interrupt");
  a_input_lamp: assert property (settled |-> led_o.input_green == $past(stat_i.in_ok, 3)
    && mon_oe_o.input_good_output == !$past(stat_i.in_ok, 3))
    else $error("input lamp or input good wrong");
  a_fault_lamp: assert property (settled && fc($past(stat_i, 3)) |-> led_o.fault_lamp
    && !led_o.output_green && mon_oe_o.fault && mon_oe_o.output_good_signal)
    else $error("fault not shown");
  a_normal_lamps: assert property (settled && !fc($past(stat_i, 3)) && !sd_any |->
    led_o.output_green && !led_o.fault_lamp && !mon_oe_o.fault && !mon_oe_o.output_good_signal)
    else $error("fault shown without cause");
  a_temp_good: assert property (settled && !sd_any |-> mon_oe_o.temp_good ==
    ($past(stat_i.ot_alarm, 3) || $past(stat_i.ot_fault, 3)))
    else $error("temperature good wrong");
  a_warn_time: assert property ($rose(shutdown_o) |->
    alarm_cnt_r >= WARN_CYCLES && alarm_cnt_r <= WARN_CYCLES + 5)
    else $error("shutdown at wrong warning time");
  a_warn_release: assert property (s_alarm_quiet |=> !shutdown_o)
    else $error("shutdown held after recovery");
  a_sda_turn: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
endmodule
bind pspt_top pspt_sva #(.WARN_CYCLES(WARN_CYCLES)) u_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .scl_i(scl_i), .stat_i(stat_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .led_o(led_o), .mon_o(mon_o),
  .mon_oe_o(mon_oe_o), .host_alert_line_o(host_alert_line_o), .host_alert_line_oe_o(host_alert_line_oe_o),
  .unit_presence_flag_o(unit_presence_flag_o), .unit_presence_flag_oe_o(unit_presence_flag_oe_o),
  .shutdown_o(shutdown_o));

/* sim/pspt_host.sv */
// Behavioural serial bus host, clock at 160 ns
`timescale 1ns/100ps
module pspt_host (
  input wire logic clk_i, // System clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock
  output logic sda_oe_o // High pulls data low
);
  // Lines idle released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Wait whole cycles
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    w(1);
    sda_oe_o <= 1'b0;
    w(4);
    scl_o <= 1'b1;
    w(8);
    sda_oe_o <= 1'b1;
    w(8);
    scl_o <= 1'b0;
  endtask
  // One bit, data changed mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    w(4);
    sda_oe_o <= !b;
    w(4);
    scl_o <= 1'b1;
    w(4);
    s = sda_i;
    w(4);
    scl_o <= 1'b0;
  endtask
  // Byte msb first, then acknowledge bit
  task automatic xbyte(input logic [7:0] tx, input logic hack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(hack, ack);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    w(4);
    sda_oe_o <= 1'b1;
    w(4);
    scl_o <= 1'b1;
    w(8);
    sda_oe_o <= 1'b0;
    w(8);
  endtask
endmodule

/* sim/tb_psu_status_pmbus_target.sv */
// Self-checking bench of the supply status block and its serial targets
`timescale 1ns/100ps
module tb_psu_status_pmbus_target import pspt_pkg::*; ;
  typedef struct packed {
    logic [7:0] stat; // Status applied
    logic [2:0] led; // Lamps expected
    logic [3:0] mon; // Sink enables expected
  } pspt_row_t;
  localparam int WARN = 50; // Short warning
  logic sys_clk_i, resetn_i, scl, host_oe, sda_oe, wp, alert_oe, pres_oe, shutdown, ok;
  logic [2:0] strap; // Strap levels, open reads one
  pspt_stat_t stat_i; // Status inputs
  pspt_led_t led_o; // Lamps
  pspt_mon_t mon_oe_o; // Monitor sinks
  logic [7:0] r0, r1; // Read bytes
  int n_mismatch = 0;
  int n_tests = 0;
  wire sda = !(host_oe | sda_oe); // Pulled-up wire
  // Rows of status against lamps and monitor sinks
  pspt_row_t rows [8] = '{'{8'he0, 3'h6, 4'h0}, '{8'h20, 3'h1, 4'he}, '{8'hf0, 3'h5, 4'hc},
    '{8'he8, 3'h5, 4'hc}, '{8'he4, 3'h6, 4'h1}, '{8'he2, 3'h5, 4'hd}, '{8'hc0, 3'h5, 4'hc},
    '{8'he1, 3'h6, 4'h0}};
  logic [7:0] bad [12] = '{CMD_FAN_CMD, CMD_FAN_STAT, CMD_RD_VIN, CMD_RD_IIN, CMD_RD_FAN1, CMD_RD_FAN2,
    CMD_RD_PIN, CMD_LEG_FAN1, CMD_LEG_FAN2, CMD_LEG_VIN, CMD_LEG_IIN, CMD_LEG_PIN};
  pspt_top #(.WARN_CYCLES(WARN)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .strap_select_high_i(strap[2]), .strap_select_mid_i(strap[1]),
    .strap_select_low_i(strap[0]), .write_protect_i(wp), .stat_i(stat_i), .led_o(led_o), .mon_o(),
    .mon_oe_o(mon_oe_o), .host_alert_line_o(), .host_alert_line_oe_o(alert_oe), .unit_presence_flag_o(),
    .unit_presence_flag_oe_o(pres_oe), .shutdown_o(shutdown));
  pspt_host host (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Address write, nw bytes, optional restart and two-byte read
  task automatic xact(input logic [6:0] dev, input logic [31:0] wb, input int nw, input bit rd,
    output logic [7:0] d0, output logic [7:0] d1, output logic ack_all);
    logic a;
    logic [7:0] d;
    host.start();
    host.xbyte({dev, 1'b0}, 1'b1, d, a);
    ack_all = !a;
    for (int i = 0; i < nw; i++) begin
      host.xbyte(wb[31 - 8 * i -: 8], 1'b1, d, a);
      ack_all = ack_all & !a;
    end
    if (rd) begin
      host.start();
      host.xbyte({dev, 1'b1}, 1'b1, d, a);
      host.xbyte(8'hff, 1'b0, d0, a);
      host.xbyte(8'hff, 1'b1, d1, a);
    end
    host.stop();
  endtask
  // Watchdog
  initial begin
    cyc(60000);
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    stat_i = 8'he0;
    strap = 3'h7;
    wp = 1'b1;
    cyc(20);
    chk({6'h0, pres_oe, sda_oe}, 8'h2);
    resetn_i <= 1'b1;
    cyc(8);
    // Table rows, vendor byte read back each time
    foreach (rows[i]) begin
      stat_i <= rows[i].stat;
      cyc(8);
      chk({5'h0, led_o}, {5'h0, rows[i].led});
      chk({3'h0, alert_oe, mon_oe_o}, {3'h0, rows[i].stat[0], rows[i].mon});
      xact({MCU_ADDR_HI, 3'h7}, {CMD_STATUS, 24'h0}, 1, 1'b1, r0, r1, ok);
      chk({4'h0, r0[7:5], ok}, {4'h0, 2'b00, !rows[i].stat[0], 1'b1});
      chk({3'h0, r0[4:0]}, {3'h0, !rows[i].stat[7], rows[i].stat[2], |rows[i].stat[2:1], rows[i].stat[3], rows[i].stat[4]});
      cyc(1);
    end
    stat_i <= 8'he0;
    $display("status rows done");
    // Straps: own addresses acked, neighbour refused
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      cyc(8);
      xact({MCU_ADDR_HI, 3'(s)}, 32'h0, 0, 1'b0, r0, r1, ok);
      chk({7'h0, ok}, 8'h1);
      xact({EEP_ADDR_HI, 3'(s)}, 32'h0, 0, 1'b0, r0, r1, ok);
      chk({7'h0, ok}, 8'h1);
      xact({MCU_ADDR_HI, 3'(s) ^ 3'h4}, 32'h0, 0, 1'b0, r0, r1, ok);
      chk({7'h0, ok}, 8'h0);
    end
    $display("address test done");
    foreach (bad[i]) begin
      xact({MCU_ADDR_HI, 3'h7}, {bad[i], 24'h0}, 1, 1'b0, r0, r1, ok);
      chk({7'h0, ok}, 8'h0);
    end
    $display("unsupported test done");
    // Storage boundary: last byte kept, next dropped
    xact({MCU_ADDR_HI, 3'h7}, {CMD_NV, 8'h5f, 8'ha5, 8'h3c}, 4, 1'b0, r0, r1, ok);
    xact({MCU_ADDR_HI, 3'h7}, {CMD_NV, 8'h5f, 16'h0}, 2, 1'b1, r0, r1, ok);
    chk(r0, 8'ha5);
    chk(r1, ERASED_BYTE);
    // Identity memory: protected, then open with wrap
    xact({EEP_ADDR_HI, 3'h7}, {8'h7f, 8'h11, 16'h0}, 2, 1'b0, r0, r1, ok);
    xact({EEP_ADDR_HI, 3'h7}, {8'h7f, 24'h0}, 1, 1'b1, r0, r1, ok);
    chk(r0, ERASED_BYTE);
    wp <= 1'b0;
    cyc(8);
    xact({EEP_ADDR_HI, 3'h7}, {8'h7f, 8'h22, 8'h23, 8'h0}, 3, 1'b0, r0, r1, ok);
    xact({EEP_ADDR_HI, 3'h7}, {8'h7f, 24'h0}, 1, 1'b1, r0, r1, ok);
    chk({r0[3:0], r1[3:0]}, 8'h23);
    $display("memory test done");
    // Warning then shutdown, release on recovery
    stat_i <= 8'he4;
    cyc(WARN - 5);
    chk({7'h0, shutdown}, 8'h0);
    cyc(15);
    chk({4'h0, shutdown, led_o}, 8'hd);
    stat_i <= 8'he0;
    cyc(8);
    chk({4'h0, shutdown, led_o}, 8'h6);
    $display("thermal test done");
    final_report();
  end
endmodule
